// file: src/adc_gain_irq_counter_config.sv
// Gain storage, interrupt gating, counters and serial calibration load
// for a multi-channel converter. Assumes the bus pins arrive
// asynchronously and that converter-side inputs share SYS_CLK_I.
`timescale 1ns/1ps
// How it works
// - Interrupt only when enabled, on FIFO half-full or end of scan.
// - Frequency counter ticks at 10 MHz, divides by n, 1 < n < 65536.
// - Scan counter becomes a 32-bit divider when not counter-timed.
// - Gain code 0..3 picks narrower ranges within the jumpered span.
// - Every channel gain code is zero, unity gain, after reset.
// - Offset 4 holds channels 0-3 gains, offset 5 channels 4-7.
// - Channels 8-15 reuse the gain of channels 0-7.
// - Calibration pots stay mid-range until software loads them.
// - Output converter and pots are loaded one bit per operation.
// - Mux gives sixteen single-ended or eight balanced inputs.
module adc_gain_irq_counter_config
   import adc_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_I,
   // Stacked I/O bus, strobes active low
   input  wire logic [4:0]        IO_ADDR_I,
   input  wire logic [7:0]        IO_DATA_I,
   input  wire logic              IO_WR_N_I,
   input  wire logic              IO_RD_N_I,
   output logic      [7:0]        IO_DATA_O,
   output logic                   IO_DATA_OE_O,
   // Jumpers
   input  wire logic              HIGH_GAIN_SPAN_SELECT_I,
   input  wire logic              BIPOLAR_I,
   input  wire logic              EIGHT_BALANCED_INPUTS_I,
   // Converter side
   input  wire logic [3:0]        CHANNEL_I,
   input  wire logic              FIFO_HALF_FULL_I,
   input  wire logic              SCAN_DONE_I,
   input  wire logic              HALF_FULL_IRQ_EN_I,
   input  wire logic              SCAN_IRQ_EN_I,
   input  wire logic              COUNTER_TIMED_MODE_I,
   output logic      [1:0]        GAIN_CODE_O,
   output logic      [3:0]        MUX_CHANNEL_O,
   output logic                   MUX_BALANCED_O,
   output logic                   RANGE_INVALID_O,
   output logic                   IRQ_O,
   // Counters
   input  wire logic [FREQ_W-1:0] FREQ_DIVISOR_I,
   input  wire logic [SCAN_W-1:0] SCAN_DIVISOR_I,
   output logic                   FREQ_OUT_O,
   output logic                   SCAN_OUT_O,
   // Serial load of output converter and calibration pots
   input  wire logic              SERIAL_BIT_I,
   input  wire logic              SERIAL_SHIFT_I,
   input  wire logic              POT_LOAD_I,
   output logic                   SERIAL_DATA_O,
   output logic                   SERIAL_CLK_O,
   output logic                   POT_MIDRANGE_O
);
   import adc_cfg_pkg::*;

   // Gain code of one channel from a packed register pair
   function automatic logic [1:0] gain_of(input logic [15:0] regs,
                                          input logic [2:0]  idx);
      gain_of = regs[{idx, 1'b0} +: GAIN_W];
   endfunction

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic              wr_n_prev_r;
   logic              mode_s1_r;
   logic              mode_s2_r;
   logic [1:0]        jmp_s1_r;      // Span and polarity jumpers, stage 1
   logic [1:0]        jmp_s2_r;      // Span and polarity jumpers, stage 2
   logic [7:0]        gain_low_r;
   logic [7:0]        gain_low_nxt;
   logic [7:0]        gain_high_r;
   logic [7:0]        gain_high_nxt;
   logic [7:0]        rd_data_r;
   logic [7:0]        rd_data_nxt;
   logic              rd_oe_r;
   logic              rd_oe_nxt;
   logic [4:0]        s_addr;
   logic [7:0]        s_data;
   logic              s_wr_n;
   logic              s_rd_n;
   logic              wr_done;
   logic [1:0]        gain_r;
   logic [1:0]        gain_nxt;
   logic [3:0]        mux_r;
   logic [3:0]        mux_nxt;
   logic              irq_r;
   logic              irq_nxt;
   logic              range_r;
   logic              range_nxt;
   logic [1:0]        tick_cnt_r;
   logic [1:0]        tick_cnt_nxt;
   logic              tick;
   logic              ser_data_r;
   logic              ser_data_nxt;
   logic              ser_clk_r;
   logic              ser_clk_nxt;
   logic              pot_mid_r;
   logic              pot_mid_nxt;

   // Bus pins and all jumpers pass two flops first
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         sync1_r     <= {SYNC_W{1'b1}};
         sync2_r     <= {SYNC_W{1'b1}};
         wr_n_prev_r <= 1'b1;
         mode_s1_r   <= 1'b0;
         mode_s2_r   <= 1'b0;
         jmp_s1_r    <= 2'h3;
         jmp_s2_r    <= 2'h3;
      end
      else
      begin
         sync1_r     <= {IO_ADDR_I, IO_DATA_I, IO_WR_N_I, IO_RD_N_I};
         sync2_r     <= sync1_r;
         wr_n_prev_r <= sync2_r[1];
         mode_s1_r   <= EIGHT_BALANCED_INPUTS_I;
         mode_s2_r   <= mode_s1_r;
         jmp_s1_r    <= {HIGH_GAIN_SPAN_SELECT_I, BIPOLAR_I};
         jmp_s2_r    <= jmp_s1_r;
      end
   end

   assign s_addr  = sync2_r[14:10];
   assign s_data  = sync2_r[9:2];
   assign s_wr_n  = sync2_r[1];
   assign s_rd_n  = sync2_r[0];
   // Write taken at strobe release, when data has long settled
   assign wr_done = s_wr_n && !wr_n_prev_r;

   // Gain registers and read-back; unmapped reads leave the bus undriven
   always_comb
   begin
      gain_low_nxt  = gain_low_r;
      gain_high_nxt = gain_high_r;
      rd_data_nxt   = rd_data_r;
      rd_oe_nxt     = 1'b0;
      if (wr_done && s_addr == GAIN_LOW_OFS)
         gain_low_nxt = s_data;
      if (wr_done && s_addr == GAIN_HIGH_OFS)
         gain_high_nxt = s_data;
      if (!s_rd_n && s_addr == GAIN_LOW_OFS)
      begin
         rd_oe_nxt   = 1'b1;
         rd_data_nxt = gain_low_r;
      end
      else if (!s_rd_n && s_addr == GAIN_HIGH_OFS)
      begin
         rd_oe_nxt   = 1'b1;
         rd_data_nxt = gain_high_r;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         gain_low_r  <= GAIN_RESET;
         gain_high_r <= GAIN_RESET;
         rd_data_r   <= 8'h00;
         rd_oe_r     <= 1'b0;
      end
      else
      begin
         gain_low_r  <= gain_low_nxt;
         gain_high_r <= gain_high_nxt;
         rd_data_r   <= rd_data_nxt;
         rd_oe_r     <= rd_oe_nxt;
      end
   end

   // Gain and mux select follow the current channel one cycle later
   always_comb
   begin
      gain_nxt = gain_of({gain_high_r, gain_low_r}, CHANNEL_I[2:0]);
      if (mode_s2_r)
         mux_nxt = {1'b0, CHANNEL_I[2:0]};
      else
         mux_nxt = CHANNEL_I;
      // End of scan is a pulse; half-full stays up while the FIFO is deep
      irq_nxt = (HALF_FULL_IRQ_EN_I && FIFO_HALF_FULL_I) ||
                (SCAN_IRQ_EN_I && SCAN_DONE_I);
      // Low span cannot be unipolar; flag it for the range decode
      range_nxt = !jmp_s2_r[1] && !jmp_s2_r[0];
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         gain_r <= 2'h0;
         mux_r  <= 4'h0;
         irq_r  <= 1'b0;
         range_r <= 1'b0;
      end
      else
      begin
         gain_r <= gain_nxt;
         mux_r  <= mux_nxt;
         irq_r  <= irq_nxt;
         range_r <= range_nxt;
      end
   end

   // 10 MHz count enable from the 40 MHz clock
   always_comb
   begin
      tick         = (tick_cnt_r == TICK_LAST);
      tick_cnt_nxt = tick ? TICK_RESET : tick_cnt_r + 2'h1;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
         tick_cnt_r <= TICK_RESET;
      else
         tick_cnt_r <= tick_cnt_nxt;
   end

   ctr_if #(.W(FREQ_W)) freq_c ();
   ctr_if #(.W(SCAN_W)) scan_c ();

   assign freq_c.tick    = tick;
   assign freq_c.run     = 1'b1;
   assign freq_c.divisor = FREQ_DIVISOR_I;
   assign scan_c.tick    = tick;
   // Free for frequency output only outside counter-timed modes
   assign scan_c.run     = !COUNTER_TIMED_MODE_I;
   assign scan_c.divisor = SCAN_DIVISOR_I;

   freq_divider #(.W(FREQ_W)) u_freq
   (
      .sys_clk_i (SYS_CLK_I),
      .reset_i   (RESET_I),
      .c         (freq_c.ctr)
   );

   freq_divider #(.W(SCAN_W)) u_scan
   (
      .sys_clk_i (SYS_CLK_I),
      .reset_i   (RESET_I),
      .c         (scan_c.ctr)
   );

   // Serial loader: each shift request is one bit, clocked out over two
   // system cycles so the parts see data settle before the clock edge
   always_comb
   begin
      ser_data_nxt = ser_data_r;
      ser_clk_nxt  = 1'b0;
      pot_mid_nxt  = pot_mid_r;
      if (SERIAL_SHIFT_I)
         ser_data_nxt = SERIAL_BIT_I;
      if (ser_clk_r == 1'b0 && ser_data_r == ser_data_nxt && SERIAL_SHIFT_I)
         ser_clk_nxt = 1'b1;
      if (POT_LOAD_I)
         pot_mid_nxt = 1'b0;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         ser_data_r <= 1'b0;
         ser_clk_r  <= 1'b0;
         pot_mid_r  <= 1'b1;
      end
      else
      begin
         ser_data_r <= ser_data_nxt;
         ser_clk_r  <= ser_clk_nxt;
         pot_mid_r  <= pot_mid_nxt;
      end
   end

   // Jumpers only move with power off, so up to three cycles of latency is free
   assign RANGE_INVALID_O = range_r;
   assign GAIN_CODE_O     = gain_r;
   assign MUX_CHANNEL_O   = mux_r;
   assign MUX_BALANCED_O  = mode_s2_r;
   assign IRQ_O           = irq_r;
   assign IO_DATA_O       = rd_data_r;
   assign IO_DATA_OE_O    = rd_oe_r;
   assign FREQ_OUT_O      = freq_c.wave;
   assign SCAN_OUT_O      = scan_c.wave;
   assign SERIAL_DATA_O   = ser_data_r;
   assign SERIAL_CLK_O    = ser_clk_r;
   assign POT_MIDRANGE_O  = pot_mid_r;
endmodule // adc_gain_irq_counter_config

// file: src/adc_cfg_pkg.sv
// Constants shared by the converter configuration block and its counters.
// Assumes a 40 MHz system clock and an 8-bit stacked I/O bus.
package adc_cfg_pkg;
   // Register offsets within the board's 32-byte window
   localparam logic [4:0] GAIN_LOW_OFS  = 5'h04;
   localparam logic [4:0] GAIN_HIGH_OFS = 5'h05;
   // Gain codes after reset: code 0 is unity gain on every channel
   localparam logic [7:0] GAIN_RESET    = 8'h00;
   localparam int         GAIN_W        = 2;
   // Timing: the counters run from a 10 MHz tick made from the system clock
   localparam int         SYS_CLK_HZ    = 40000000;
   localparam int         CTR_CLK_HZ    = 10000000;
   localparam int         TICK_DIV      = SYS_CLK_HZ / CTR_CLK_HZ;
   localparam logic [1:0] TICK_LAST     = 2'(TICK_DIV - 1);
   localparam logic [1:0] TICK_RESET    = 2'h0;
   // Counter widths
   localparam int         FREQ_W        = 16;
   localparam int         SCAN_W        = 32;
   // Bus input synchroniser width: addr, data, write strobe, read strobe
   localparam int         SYNC_W        = 15;
endpackage

// file: src/ctr_if.sv
// Control and output of one programmable divider counter.
// Assumes all members are on the system clock.
`timescale 1ns/1ps
interface ctr_if #(parameter int W = 16);
   logic         tick;     // 10 MHz count enable
   logic         run;      // Counter allowed to count
   logic [W-1:0] divisor;  // Divide ratio n
   logic         wave;     // Divided output
   modport ctrl (output tick, output run, output divisor, input wave);
   modport ctr  (input tick, input run, input divisor, output wave);
endinterface

// file: src/freq_divider.sv
// Divide-by-n counter clocked by a one-cycle enable.
// Assumes n above 1; smaller ratios hold the output low.
`timescale 1ns/1ps
module freq_divider #(parameter int W = 16)
(
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   ctr_if.ctr        c
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic         wave_r;
   logic         wave_nxt;
   logic         ratio_ok;

   // Count down from n-1; output high for the upper half of the period
   always_comb
   begin
      ratio_ok  = (c.divisor > W'(1));
      count_nxt = count_r;
      wave_nxt  = wave_r;
      if (!c.run || !ratio_ok)
      begin
         count_nxt = '0;
         wave_nxt  = 1'b0;
      end
      else if (c.tick)
      begin
         if (count_r == '0)
            count_nxt = c.divisor - W'(1);
         else
            count_nxt = count_r - W'(1);
         wave_nxt = (count_nxt >= (c.divisor >> 1));
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         count_r <= '0;
         wave_r  <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         wave_r  <= wave_nxt;
      end
   end

   assign c.wave = wave_r;
endmodule // freq_divider

// file: dv/adc_cfg_sva.sv
// Checker for the converter configuration block, top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module adc_cfg_sva
   import adc_cfg_pkg::*;
(
   // Clock, reset, converter side, jumpers, frequency divisor and serial load inputs
   input wire logic                   SYS_CLK_I,
   input wire logic                   RESET_I,
   input wire logic                   FIFO_HALF_FULL_I,
   input wire logic                   SCAN_DONE_I,
   input wire logic                   HALF_FULL_IRQ_EN_I,
   input wire logic                   SCAN_IRQ_EN_I,
   input wire logic                   COUNTER_TIMED_MODE_I,
   input wire logic                   HIGH_GAIN_SPAN_SELECT_I,
   input wire logic                   BIPOLAR_I,
   input wire logic [FREQ_W-1:0]      FREQ_DIVISOR_I,
   input wire logic                   SERIAL_BIT_I,
   input wire logic                   SERIAL_SHIFT_I,
   input wire logic                   POT_LOAD_I,
   // Watched outputs
   input wire logic [1:0]             GAIN_CODE_O,
   input wire logic                   RANGE_INVALID_O,
   input wire logic                   IRQ_O,
   input wire logic                   FREQ_OUT_O,
   input wire logic                   SCAN_OUT_O,
   input wire logic                   SERIAL_DATA_O,
   input wire logic                   SERIAL_CLK_O,
   input wire logic                   POT_MIDRANGE_O
);
   import adc_cfg_pkg::*;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);
   // Interrupt is the gated cause one cycle late, never ungated
   a_irq_follows_cause:
      assert property ($past(!RESET_I) |-> IRQ_O == $past((HALF_FULL_IRQ_EN_I
         & FIFO_HALF_FULL_I) | (SCAN_IRQ_EN_I & SCAN_DONE_I)))
      else $error("irq differs from its gated causes");
   a_range_flag:
      assert property ((!$past(RESET_I) && !$past(RESET_I, 2)
         && !$past(RESET_I, 3)) |-> RANGE_INVALID_O ==
         $past(!HIGH_GAIN_SPAN_SELECT_I && !BIPOLAR_I, 3))
      else $error("range flag wrong");
   a_gain_unity_reset:
      assert property ($fell(RESET_I) |-> GAIN_CODE_O == 2'h0)
      else $error("gain not zero after reset");
   a_pot_mid_reset:
      assert property ($fell(RESET_I) |-> POT_MIDRANGE_O)
      else $error("pots not mid-range after reset");
   a_pot_load_sticks:
      assert property (POT_LOAD_I || !POT_MIDRANGE_O |=> !POT_MIDRANGE_O)
      else $error("pot default not left after load");
   // Ratios of one or less would be outside the counter's range
   a_freq_idle_low:
      assert property ((FREQ_DIVISOR_I < 16'h2) [*8] |-> !FREQ_OUT_O)
      else $error("frequency output runs with n below 2");
   a_scan_stopped:
      assert property (COUNTER_TIMED_MODE_I [*8] |-> !SCAN_OUT_O)
      else $error("scan divider runs in timed mode");
   a_serial_data:
      assert property (SERIAL_SHIFT_I |=> SERIAL_DATA_O == $past(SERIAL_BIT_I))
      else $error("serial data not shifted");
   a_serial_pulse:
      assert property (SERIAL_CLK_O |-> $past(SERIAL_SHIFT_I) ##1 !SERIAL_CLK_O)
      else $error("serial clock not a single shift pulse");
endmodule // adc_cfg_sva

bind adc_gain_irq_counter_config adc_cfg_sva adc_cfg_sva_i (.SYS_CLK_I,
   .RESET_I, .FIFO_HALF_FULL_I, .SCAN_DONE_I, .HALF_FULL_IRQ_EN_I,
   .SCAN_IRQ_EN_I, .COUNTER_TIMED_MODE_I, .HIGH_GAIN_SPAN_SELECT_I,
   .BIPOLAR_I, .FREQ_DIVISOR_I, .SERIAL_BIT_I, .SERIAL_SHIFT_I, .POT_LOAD_I,
   .GAIN_CODE_O, .RANGE_INVALID_O, .IRQ_O, .FREQ_OUT_O, .SCAN_OUT_O,
   .SERIAL_DATA_O, .SERIAL_CLK_O, .POT_MIDRANGE_O);

// file: dv/host_bus_model.sv
// Host side of the stacked I/O bus: byte writes and reads.
// Assumes tasks are called just after a falling clock edge.
`timescale 1ns/1ps
module host_bus_model
(
   // Clock and bus
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] data_i,
   input  wire logic       oe_i,
   output logic      [4:0] addr_o,
   output logic      [7:0] data_o,
   output logic            wr_n_o,
   output logic            rd_n_o
);
   // Idle bus
   initial
   begin
      addr_o = 5'h1f;
      data_o = 8'h5a;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
   end
   // Strobes stay three or more cycles on each level
   task automatic gap(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Write is taken at strobe release; hold through the sync stages
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      addr_o = a;
      data_o = d;
      wr_n_o = 1'b0;
      gap(4);
      wr_n_o = 1'b1;
      gap(3);
      // Released data must not look like the last value; changed a cycle
      // early so a following write never drives it twice in one step
      data_o = ~d;
      gap(1);
   endtask
   // Answer is settled five cycles after the strobe falls
   task automatic rd(input logic [4:0] a, output logic [7:0] d,
                     output logic oe);
      addr_o = a;
      rd_n_o = 1'b0;
      gap(5);
      d = data_i;
      oe = oe_i;
      rd_n_o = 1'b1;
      gap(4);
   endtask
endmodule // host_bus_model

// file: dv/testbench.sv
// Self-checking bench for the converter configuration block.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/1ps
module testbench;
   import adc_cfg_pkg::*;
   logic              clk, rst, hg, bip, bal, hf, sd, hfe, sde, tm;
   logic              sb, ss, pl, wr_n, rd_n, oe, mbal, rinv, irq;
   logic              fo, so, sdat, sclk, pmid, roe;
   logic [3:0]        ch, mch;
   logic [1:0]        gc;
   logic [4:0]        addr;
   logic [7:0]        din, dout, g4, g5, rv;
   logic [FREQ_W-1:0] fdiv;
   logic [SCAN_W-1:0] sdiv;
   int                n_errors, compares, seed, cyc, i, k, pulses;
   adc_gain_irq_counter_config adc_gain_irq_counter_config_i (
      .SYS_CLK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr), .IO_DATA_I(din),
      .IO_WR_N_I(wr_n), .IO_RD_N_I(rd_n), .IO_DATA_O(dout),
      .IO_DATA_OE_O(oe), .HIGH_GAIN_SPAN_SELECT_I(hg), .BIPOLAR_I(bip),
      .EIGHT_BALANCED_INPUTS_I(bal), .CHANNEL_I(ch), .FIFO_HALF_FULL_I(hf),
      .SCAN_DONE_I(sd), .HALF_FULL_IRQ_EN_I(hfe), .SCAN_IRQ_EN_I(sde),
      .COUNTER_TIMED_MODE_I(tm), .GAIN_CODE_O(gc), .MUX_CHANNEL_O(mch),
      .MUX_BALANCED_O(mbal), .RANGE_INVALID_O(rinv), .IRQ_O(irq),
      .FREQ_DIVISOR_I(fdiv), .SCAN_DIVISOR_I(sdiv), .FREQ_OUT_O(fo),
      .SCAN_OUT_O(so), .SERIAL_BIT_I(sb), .SERIAL_SHIFT_I(ss),
      .POT_LOAD_I(pl), .SERIAL_DATA_O(sdat), .SERIAL_CLK_O(sclk),
      .POT_MIDRANGE_O(pmid));
   host_bus_model host_bus_model_i (.sys_clk_i(clk), .data_i(dout),
      .oe_i(oe), .addr_o(addr), .data_o(din), .wr_n_o(wr_n),
      .rd_n_o(rd_n));
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Count serial clock pulses
   always @(negedge clk) if (sclk === 1'b1) pulses++;
   // Expected gain: register by channel bit 2, field by bits 1:0
   function automatic logic [1:0] gain_exp(input logic [3:0] c);
      logic [7:0] r;
      r = c[2] ? g5 : g4;
      return r[{c[1:0], 1'b0} +: 2];
   endfunction
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d, comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Wait for the next rise of a divided wave, bounded
   task automatic rise(input logic sel, inout int c);
      while ((sel ? so : fo) === 1'b1 && c < 400)
      begin
         @(negedge clk);
         c++;
      end
      while ((sel ? so : fo) !== 1'b1 && c < 400)
      begin
         @(negedge clk);
         c++;
      end
   endtask
   // Second full period after a change, so the old ratio has drained
   task automatic per(input logic sel, output int c);
      c = 0;
      rise(sel, c);
      rise(sel, c);
      c = 0;
      rise(sel, c);
   endtask
   // Timeout well beyond the expected run
   initial
   begin
      #1000000;
      n_errors++;
      end_of_test();
   end
   // Main sequence, inputs change at falling edges
   initial
   begin
      seed = 57013;
      {n_errors, compares, pulses} = 0;
      {rst, hg, bip, tm} = 4'hf;
      {bal, hf, sd, hfe, sde, sb, ss, pl} = 8'h00;
      ch = 4'h0;
      fdiv = 16'h1;
      sdiv = 32'h3;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("pot default", 1, pmid);
      for (k = 4; k < 8; k++)
      begin
         host_bus_model_i.rd(5'(k), rv, roe);
         chk("read enable", k < 6, roe);
         if (k < 6) chk("reset gain", 0, rv);
      end
      for (i = 0; i < 4; i++)
      begin
         bal = i[0];
         g4 = 8'($random(seed));
         g5 = 8'($random(seed));
         host_bus_model_i.wr(5'h05, g5);
         host_bus_model_i.wr(5'h04, g4);
         host_bus_model_i.wr(5'h07, ~g4);
         host_bus_model_i.rd(5'h04, rv, roe);
         chk("low gains", g4, rv);
         host_bus_model_i.rd(5'h05, rv, roe);
         chk("high gains", g5, rv);
         chk("balanced", bal, mbal);
         for (k = 0; k < 16; k++)
         begin
            ch = 4'(k);
            @(negedge clk);
            chk("gain code", gain_exp(ch), gc);
            chk("mux", bal ? {1'b0, ch[2:0]} : ch, mch);
         end
      end
      for (k = 0; k < 4; k++)
      begin
         {hg, bip} = 2'(k);
         repeat (3) @(negedge clk);
         chk("range flag", k == 0, rinv);
      end
      repeat (40)
      begin
         {hfe, sde, hf, sd} = 4'($random(seed));
         @(negedge clk);
         chk("irq", (hfe & hf) | (sde & sd), irq);
      end
      {hf, sd, tm} = 3'h0;
      for (i = 0; i < 3; i++)
      begin
         fdiv = (i == 0) ? 16'h2 : 16'(2 + ($random(seed) & 7));
         sdiv = (i == 0) ? 32'h2 : 32'(3 + ($random(seed) & 7));
         per(1'b0, cyc);
         chk("freq period", 32'(4 * fdiv), 32'(cyc));
         per(1'b1, cyc);
         chk("scan period", 4 * sdiv, 32'(cyc));
      end
      tm = 1'b1;
      pulses = 0;
      repeat (8)
      begin
         sb = 1'($random(seed));
         ss = 1'b1;
         @(negedge clk);
         chk("serial data", sb, sdat);
         @(negedge clk);
         ss = 1'b0;
         repeat (2) @(negedge clk);
      end
      chk("serial pulses", 8, pulses);
      pl = 1'b1;
      @(negedge clk);
      pl = 1'b0;
      @(negedge clk);
      chk("pot loaded", 0, pmid);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      host_bus_model_i.rd(5'h04, rv, roe);
      chk("gain after reset", 0, rv);
      chk("pot after reset", 1, pmid);
      end_of_test();
   end
endmodule // testbench
